/* File: pkg/mdfs_pkg.sv */
package mdfs_pkg;
	// ==========================================================
	// Timebase
	localparam int unsigned CLK_PERIOD_NS  = 5;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned DIV_W          = 18;
	localparam int unsigned MS_PER_S       = 1000;
	localparam int unsigned S_PER_MIN      = 60;
	localparam int unsigned TW             = 16;
	localparam int unsigned RW             = 21;
	// ==========================================================
	// Persistence and pause times, as printed
	localparam int unsigned TRIAC_FAIL_S   = 1;
	localparam int unsigned DIR_FAIL_S     = 3;
	localparam int unsigned TACHO_FAIL_S   = 3;
	localparam int unsigned OPEN_NTC_S     = 20;
	localparam int unsigned MSG_FAIL_S     = 2;
	localparam int unsigned COMM_FAIL_S    = 25;
	localparam int unsigned PAUSE_DIR_MIN  = 5;
	localparam int unsigned PAUSE_LAST_MIN = 20;
	localparam int unsigned PAUSE_LONG_MIN = 2;
	localparam int unsigned PAUSE_STD_S    = 10;
	// Same times in milliseconds
	localparam logic [TW-1:0] TRIAC_FAIL_MS = TW'(TRIAC_FAIL_S * MS_PER_S);
	localparam logic [TW-1:0] DIR_FAIL_MS   = TW'(DIR_FAIL_S * MS_PER_S);
	localparam logic [TW-1:0] TACHO_FAIL_MS = TW'(TACHO_FAIL_S * MS_PER_S);
	localparam logic [TW-1:0] OPEN_NTC_MS   = TW'(OPEN_NTC_S * MS_PER_S);
	localparam logic [TW-1:0] MSG_FAIL_MS   = TW'(MSG_FAIL_S * MS_PER_S);
	localparam logic [TW-1:0] COMM_FAIL_MS  = TW'(COMM_FAIL_S * MS_PER_S);
	localparam logic [RW-1:0] PAUSE_DIR_MS  =
		RW'(PAUSE_DIR_MIN * S_PER_MIN * MS_PER_S);
	localparam logic [RW-1:0] PAUSE_LAST_MS =
		RW'(PAUSE_LAST_MIN * S_PER_MIN * MS_PER_S);
	localparam logic [RW-1:0] PAUSE_LONG_MS =
		RW'(PAUSE_LONG_MIN * S_PER_MIN * MS_PER_S);
	localparam logic [RW-1:0] PAUSE_STD_MS  = RW'(PAUSE_STD_S * MS_PER_S);
	// ==========================================================
	// Sensing windows in converter steps, thresholds
	localparam logic [7:0] POS_LO         = 8'h67;
	localparam logic [7:0] POS_HI         = 8'hFA;
	localparam logic [7:0] NEG_LO         = 8'h05;
	localparam logic [7:0] NEG_HI         = 8'h99;
	localparam logic [7:0] DIR_HIGH_STEPS = 8'h99;
	localparam logic signed [9:0] OPEN_TEMP_C = -10'sh00B;
	localparam logic [9:0] UV_OK_V        = 10'h0E1;
	localparam logic [9:0] OV_OK_V        = 10'h1A4;
	localparam logic [7:0] LIMP_CURRENT_DA = 8'h28;
	localparam logic [11:0] LIMP_RPM      = 12'h0C8;
	localparam logic [2:0] RETRY_TRIALS   = 3'h5;
	// ==========================================================
	// Configuration slots and reset defaults
	localparam int unsigned NCFG = 6;
	localparam logic [2:0] CFG_OC     = 3'h0;
	localparam logic [2:0] CFG_HEAT_C = 3'h1;
	localparam logic [2:0] CFG_HEAT_T = 3'h2;
	localparam logic [2:0] CFG_UV_V   = 3'h3;
	localparam logic [2:0] CFG_OV_V   = 3'h4;
	localparam logic [2:0] CFG_BUS_T  = 3'h5;
	localparam logic [TW-1:0] CFG_DEF [NCFG] = '{16'h003C, 16'h0058,
		16'h03E8, 16'h00AF, 16'h01AE, 16'h0005};
	// ==========================================================
	// Persistence timers and alarm classes
	localparam int unsigned NP = 9;
	localparam int P_TRIAC = 0, P_DIR = 1, P_TACHO = 2, P_HEAT = 3;
	localparam int P_OPEN = 4, P_UV = 5, P_OV = 6, P_MSG = 7, P_COMM = 8;
	localparam int unsigned NAL = 11;
	localparam int AL_TRIAC = 0, AL_DIR = 1, AL_TRIP = 2, AL_OC = 3;
	localparam int AL_NOTF = 4, AL_HEAT = 5, AL_UV = 6, AL_OV = 7;
	localparam int AL_MSG = 8, AL_COMM = 9, AL_FAULT = 10;
	localparam logic [NAL-1:0] RETRY_MASK   = 11'h5FE;
	localparam logic [NAL-1:0] INV_OFF_MASK = 11'h5DC;
	localparam logic [NAL-1:0] OPEN_MASK    = 11'h40C;
	localparam logic [NAL-1:0] LOCK_MASK    = 11'h010;

	typedef enum logic [1:0] {
		RS_WATCH, RS_PAUSE, RS_WAIT, RS_LATCH
	} mdfs_retry_state_type;
endpackage : mdfs_pkg

/* File: rtl/mdfs_persist.sv */
`timescale 1ns/1ps
module mdfs_persist import mdfs_pkg::*; (
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	input  wire logic          i_tick,
	input  wire logic          i_cond,
	input  wire logic [TW-1:0] i_limit,
	output logic               o_qual
);
	logic [TW-1:0] cnt_reg;
	logic [TW-1:0] cnt_next;

	// ==========================================================
	// Millisecond persistence count
	always_comb begin
		cnt_next = cnt_reg;
		if (!i_cond) begin
			cnt_next = '0; // [RQ23]
		end else if (i_tick && (cnt_reg != {TW{1'b1}})) begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign o_qual = i_cond && (cnt_reg >= i_limit);

	AST_PERSIST_RESTART: assert property ( // [RQ23]
		@(posedge i_clk) disable iff (!i_rst_n)
		(!i_cond && i_limit != '0) |=> (!o_qual || !$stable(i_limit)))
		else $error("persistence qualified right after condition cleared");
endmodule : mdfs_persist

/* File: rtl/mdfs_retry.sv */
`timescale 1ns/1ps
module mdfs_retry import mdfs_pkg::*; (
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	input  wire logic          i_tick,
	input  wire logic          i_fault,
	input  wire logic          i_retry_en,
	input  wire logic [RW-1:0] i_short,
	input  wire logic [RW-1:0] i_long,
	input  wire logic          i_reset_ok,
	output logic               o_pause,
	output logic               o_reset,
	output logic               o_latched
);
	mdfs_retry_state_type state_reg;
	mdfs_retry_state_type state_next;
	logic [2:0]           trial_reg;
	logic [2:0]           trial_next;
	logic [RW-1:0]        tmr_reg;
	logic [RW-1:0]        tmr_next;
	logic                 rst_reg;
	logic                 rst_next;

	// ==========================================================
	// Trial sequencer
	always_comb begin
		state_next = state_reg;
		trial_next = trial_reg;
		tmr_next   = tmr_reg;
		rst_next   = 1'b0;
		case (state_reg)
			RS_WATCH: begin
				if (i_fault) begin
					if (!i_retry_en || trial_reg == RETRY_TRIALS) begin
						state_next = RS_LATCH; // [RQ16]
					end else begin
						trial_next = trial_reg + 3'h1;
						tmr_next   = (trial_reg == RETRY_TRIALS - 3'h1) ?
							i_long : i_short; // [RQ4]
						state_next = RS_PAUSE;
					end
				end
			end
			RS_PAUSE: begin
				if (tmr_reg == '0) begin
					state_next = RS_WAIT;
				end else if (i_tick) begin
					tmr_next = tmr_reg - 1'b1;
				end
			end
			RS_WAIT: begin
				if (i_reset_ok) begin
					rst_next   = 1'b1; // [RQ20]
					state_next = RS_WATCH;
				end
			end
			RS_LATCH: begin
				state_next = RS_LATCH;
			end
			default: begin
				state_next = RS_WATCH;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= RS_WATCH;
			trial_reg <= 3'h0;
			tmr_reg   <= '0;
			rst_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			trial_reg <= trial_next;
			tmr_reg   <= tmr_next;
			rst_reg   <= rst_next;
		end
	end

	assign o_pause   = (state_reg == RS_PAUSE) || (state_reg == RS_WAIT);
	assign o_reset   = rst_reg;
	assign o_latched = (state_reg == RS_LATCH);

	AST_RESET_GATED: assert property ( // [RQ14]
		@(posedge i_clk) disable iff (!i_rst_n)
		o_reset |-> $past(i_reset_ok) && $past(state_reg == RS_WAIT))
		else $error("alarm reset sent while reset not allowed");
	AST_TRIAL_COUNT: assert property ( // [RQ16]
		@(posedge i_clk) disable iff (!i_rst_n)
		($rose(o_latched) && $past(i_retry_en)) |-> trial_reg == RETRY_TRIALS)
		else $error("fault latched before all trials were used");
endmodule : mdfs_retry

/* File: rtl/mdfs_top.sv */
`timescale 1ns/1ps
// What this block does
// RQ1: Triac sample window per mains half wave
// RQ2: Out-of-window sample over one second latches
// RQ3: Idle high sensing over three seconds: relay
// RQ4: Relay fault: five trials, 5/20 minute pauses
// RQ5: No relay fault check in electric test
// RQ6: Current trip stops motor, two-minute retries
// RQ7: Phase current over configured limit stops motor
// RQ8: No tacho three seconds after start: fault
// RQ9: Missing tacho: limp current and speed
// RQ10: Not-following latch keeps door locked
// RQ11: Heat-sink over limit for time: fault
// RQ12: Heat-sink at -11 over 20s: fault
// RQ13: Heat reset only in range; two-minute pauses
// RQ14: Undervoltage fault; reset above 225V
// RQ15: Overvoltage fault; reset below 420V
// RQ16: Five trials, ten-second unpowered pauses
// RQ17: Inverter message silence over two seconds
// RQ18: Link silence 25s latches, key ignored
// RQ19: Repeated config requests fault, door opens
// RQ20: Safe state left only by reset command
// RQ21: Heating timeout loaded, counted, skips heating
// RQ22: Latched alarms cleared only by power off
// RQ23: Persistence timers restart when condition clears
module mdfs_top import mdfs_pkg::*; #(
	parameter int unsigned P_TICK_CYCLES = TICK_CYCLES
) (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_NRST,
	input  wire logic [7:0]  I_TRIAC_SENSE,
	input  wire logic        I_SENSE_VALID,
	input  wire logic        I_HALF_POS,
	input  wire logic        I_DOOR_CLOSED,
	input  wire logic        I_TRIAC_DRIVEN,
	input  wire logic        I_RELAYS_OPEN,
	input  wire logic        I_ELEC_TEST,
	input  wire logic        I_NORMAL_CYCLE,
	input  wire logic        I_CUR_TRIP,
	input  wire logic [7:0]  I_PHASE_CURRENT,
	input  wire logic        I_SPEED_NZ,
	input  wire logic        I_MOTOR_START,
	input  wire logic        I_TACHO,
	input  wire logic [9:0]  I_HS_TEMP,
	input  wire logic [9:0]  I_BUS_VOLT,
	input  wire logic        I_INV_MSG_OK,
	input  wire logic        I_MC_LINK_OK,
	input  wire logic        I_INV_CFG_REQ,
	input  wire logic        I_CFG_WE,
	input  wire logic [2:0]  I_CFG_SEL,
	input  wire logic [15:0] I_CFG_DATA,
	input  wire logic        I_HEAT_START,
	input  wire logic        I_HEAT_TARGET,
	input  wire logic [15:0] I_HEAT_TIMEOUT_S,
	input  wire logic        I_START_PAUSE,
	output logic             O_MOTOR_OFF,
	output logic             O_INV_POWER_EN,
	output logic             O_ALARM_RESET,
	output logic             O_SAFE_STOP,
	output logic             O_DOOR_OPEN,
	output logic             O_DOOR_KEEP_LOCKED,
	output logic             O_ALARM_VALID,
	output logic [3:0]       O_ALARM_CODE,
	output logic             O_HEAT_ALARM,
	output logic             O_LIMP_EN,
	output logic [7:0]       O_LIMP_CURRENT,
	output logic [11:0]      O_LIMP_RPM
);
	logic [1:0]       rst_sync_reg;
	logic             rst_n;
	logic [DIV_W-1:0] div_reg, div_next;
	logic [9:0]       ms_reg, ms_next;
	logic             tick_reg, tick_next, sec_reg, sec_next;
	logic [3:0]       s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	logic             half_pos, door_closed, trip_f, tacho_f, tacho_edge;
	logic             tacho_d_reg;
	logic             out_reg, out_next, high_reg, high_next;
	logic             in_win, armed_reg, armed_next, seen_reg, seen_next;
	logic [TW-1:0]    cfg_reg [NCFG];
	logic [TW-1:0]    cfg_next [NCFG];
	logic [15:0]      htmr_reg, htmr_next;
	logic             hrun_reg, hrun_next, halarm_reg, halarm_next;
	logic             cfg_done_reg, cfg_done_next, inv_fault;
	logic             temp_ok;
	logic [NP-1:0]    p_cond, p_qual;
	logic [TW-1:0]    p_lim [NP];
	logic [NAL-1:0]   fault, ok, pause, areset, latched;
	logic [RW-1:0]    p_short [NAL];
	logic [RW-1:0]    p_long [NAL];
	logic [3:0]       code_reg, code_next;
	logic             valid_reg, valid_next, moff_reg, moff_next;
	logic             inv_en_reg, inv_en_next, ares_reg, ares_next;
	logic             stop_reg, stop_next, open_reg, open_next;
	logic             lock_reg, lock_next, limp_reg, limp_next;

	// ==========================================================
	// Reset release
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ==========================================================
	// Millisecond and second enables
	always_comb begin
		div_next  = div_reg + 1'b1;
		ms_next   = ms_reg;
		tick_next = 1'b0;
		sec_next  = 1'b0;
		if (div_reg == DIV_W'(P_TICK_CYCLES - 1)) begin
			div_next  = '0;
			tick_next = 1'b1;
			ms_next   = ms_reg + 10'h001;
			if (ms_reg == 10'(MS_PER_S - 1)) begin
				ms_next  = 10'h000;
				sec_next = 1'b1;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			div_reg  <= '0;
			ms_reg   <= 10'h000;
			tick_reg <= 1'b0;
			sec_reg  <= 1'b0;
		end else begin
			div_reg  <= div_next;
			ms_reg   <= ms_next;
			tick_reg <= tick_next;
			sec_reg  <= sec_next;
		end
	end

	// ==========================================================
	// Pin synchronisers, change taken when stages two and three agree
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg      <= 4'h0;
			s2_reg      <= 4'h0;
			s3_reg      <= 4'h0;
			filt_reg    <= 4'h0;
			tacho_d_reg <= 1'b0;
		end else begin
			s1_reg      <= {I_TACHO, I_CUR_TRIP, I_DOOR_CLOSED, I_HALF_POS};
			s2_reg      <= s1_reg;
			s3_reg      <= s2_reg;
			filt_reg    <= filt_next;
			tacho_d_reg <= filt_reg[3];
		end
	end
	assign half_pos    = filt_reg[0];
	assign door_closed = filt_reg[1];
	assign trip_f      = filt_reg[2];
	assign tacho_f     = filt_reg[3];
	assign tacho_edge  = tacho_f && !tacho_d_reg;

	// ==========================================================
	// Sensing, tacho, heating timeout, config, inverter restarts
	always_comb begin
		in_win = half_pos ?
			(I_TRIAC_SENSE >= POS_LO && I_TRIAC_SENSE <= POS_HI) :
			(I_TRIAC_SENSE >= NEG_LO && I_TRIAC_SENSE <= NEG_HI); // [RQ1]
		out_next  = I_SENSE_VALID ? !in_win : out_reg;
		high_next = I_SENSE_VALID ? (I_TRIAC_SENSE > DIR_HIGH_STEPS) : high_reg;
		armed_next = armed_reg;
		seen_next  = seen_reg || tacho_edge;
		if (!I_SPEED_NZ) begin
			armed_next = 1'b0;
		end else if (I_MOTOR_START) begin
			armed_next = 1'b1; // [RQ8]
			seen_next  = 1'b0;
		end
		limp_next = armed_reg && !seen_reg && !moff_reg; // [RQ9]
		htmr_next   = htmr_reg;
		hrun_next   = hrun_reg;
		halarm_next = halarm_reg && !I_START_PAUSE;
		if (I_HEAT_START) begin
			htmr_next = I_HEAT_TIMEOUT_S; // [RQ21]
			hrun_next = 1'b1;
		end else if (I_HEAT_TARGET) begin
			hrun_next = 1'b0;
		end else if (hrun_reg && sec_reg) begin
			htmr_next = (htmr_reg == 16'h0000) ? 16'h0000 : htmr_reg - 16'h0001;
			if (htmr_reg <= 16'h0001) begin
				halarm_next = 1'b1; // [RQ21]
				hrun_next   = 1'b0;
			end
		end
		for (int i = 0; i < NCFG; i++) begin
			cfg_next[i] = (I_CFG_WE && I_CFG_SEL == 3'(i)) ?
				I_CFG_DATA : cfg_reg[i];
		end
		cfg_done_next = inv_en_reg && (cfg_done_reg || I_INV_CFG_REQ);
	end
	assign inv_fault = I_INV_CFG_REQ && cfg_done_reg; // [RQ19]

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			out_reg      <= 1'b0;
			high_reg     <= 1'b0;
			armed_reg    <= 1'b0;
			seen_reg     <= 1'b0;
			limp_reg     <= 1'b0;
			htmr_reg     <= 16'h0000;
			hrun_reg     <= 1'b0;
			halarm_reg   <= 1'b0;
			cfg_done_reg <= 1'b0;
			cfg_reg      <= CFG_DEF;
		end else begin
			out_reg      <= out_next;
			high_reg     <= high_next;
			armed_reg    <= armed_next;
			seen_reg     <= seen_next;
			limp_reg     <= limp_next;
			htmr_reg     <= htmr_next;
			hrun_reg     <= hrun_next;
			halarm_reg   <= halarm_next;
			cfg_done_reg <= cfg_done_next;
			cfg_reg      <= cfg_next;
		end
	end

	// ==========================================================
	// Persistence conditions and limits
	assign temp_ok = ($signed(I_HS_TEMP) > OPEN_TEMP_C) &&
		($signed(I_HS_TEMP) <= $signed(cfg_reg[CFG_HEAT_C][9:0]));
	always_comb begin
		p_cond[P_TRIAC] = out_reg; // [RQ2]
		p_cond[P_DIR]   = door_closed && !I_TRIAC_DRIVEN && I_RELAYS_OPEN &&
			high_reg && !I_ELEC_TEST; // [RQ3] [RQ5]
		p_cond[P_TACHO] = armed_reg && !tacho_edge; // [RQ8]
		p_cond[P_HEAT]  = $signed(I_HS_TEMP) >
			$signed(cfg_reg[CFG_HEAT_C][9:0]); // [RQ11]
		p_cond[P_OPEN]  = $signed(I_HS_TEMP) <= OPEN_TEMP_C; // [RQ12]
		p_cond[P_UV]    = I_BUS_VOLT < cfg_reg[CFG_UV_V][9:0]; // [RQ14]
		p_cond[P_OV]    = I_BUS_VOLT > cfg_reg[CFG_OV_V][9:0]; // [RQ15]
		p_cond[P_MSG]   = inv_en_reg && !I_INV_MSG_OK; // [RQ17]
		p_cond[P_COMM]  = !I_MC_LINK_OK; // [RQ18]
		p_lim[P_TRIAC]  = TRIAC_FAIL_MS;
		p_lim[P_DIR]    = DIR_FAIL_MS;
		p_lim[P_TACHO]  = TACHO_FAIL_MS;
		p_lim[P_HEAT]   = cfg_reg[CFG_HEAT_T];
		p_lim[P_OPEN]   = OPEN_NTC_MS;
		p_lim[P_UV]     = cfg_reg[CFG_BUS_T];
		p_lim[P_OV]     = cfg_reg[CFG_BUS_T];
		p_lim[P_MSG]    = MSG_FAIL_MS;
		p_lim[P_COMM]   = COMM_FAIL_MS;
	end

	for (genvar g = 0; g < NP; g++) begin : g_persist
		mdfs_persist u_persist (
			.i_clk   (I_CORE_CLK),
			.i_rst_n (rst_n),
			.i_tick  (tick_reg),
			.i_cond  (p_cond[g]),
			.i_limit (p_lim[g]),
			.o_qual  (p_qual[g])
		);
	end

	// ==========================================================
	// Alarm classes and retry sequencers
	always_comb begin
		fault           = '0;
		fault[AL_TRIAC] = p_qual[P_TRIAC];
		fault[AL_DIR]   = p_qual[P_DIR];
		fault[AL_TRIP]  = trip_f; // [RQ6]
		fault[AL_OC]    = I_PHASE_CURRENT > cfg_reg[CFG_OC][7:0]; // [RQ7]
		fault[AL_NOTF]  = p_qual[P_TACHO];
		fault[AL_HEAT]  = p_qual[P_HEAT] || p_qual[P_OPEN];
		fault[AL_UV]    = p_qual[P_UV];
		fault[AL_OV]    = p_qual[P_OV];
		fault[AL_MSG]   = p_qual[P_MSG];
		fault[AL_COMM]  = p_qual[P_COMM];
		fault[AL_FAULT] = inv_fault;
		ok              = {NAL{1'b1}};
		ok[AL_HEAT]     = temp_ok; // [RQ13]
		ok[AL_UV]       = I_BUS_VOLT > UV_OK_V; // [RQ14]
		ok[AL_OV]       = I_BUS_VOLT < OV_OK_V; // [RQ15]
		for (int i = 0; i < NAL; i++) begin
			p_short[i] = PAUSE_STD_MS; // [RQ16]
			p_long[i]  = PAUSE_STD_MS;
		end
		p_short[AL_DIR]  = PAUSE_DIR_MS; // [RQ4]
		p_long[AL_DIR]   = PAUSE_LAST_MS;
		p_short[AL_TRIP] = PAUSE_LONG_MS; // [RQ6]
		p_long[AL_TRIP]  = PAUSE_LONG_MS;
		p_short[AL_HEAT] = PAUSE_LONG_MS; // [RQ13]
		p_long[AL_HEAT]  = PAUSE_LONG_MS;
	end

	for (genvar g = 0; g < NAL; g++) begin : g_retry
		mdfs_retry u_retry (
			.i_clk      (I_CORE_CLK),
			.i_rst_n    (rst_n),
			.i_tick     (tick_reg),
			.i_fault    (fault[g]),
			.i_retry_en (I_NORMAL_CYCLE && RETRY_MASK[g]),
			.i_short    (p_short[g]),
			.i_long     (p_long[g]),
			.i_reset_ok (ok[g]),
			.o_pause    (pause[g]),
			.o_reset    (areset[g]),
			.o_latched  (latched[g])
		);
	end

	// ==========================================================
	// Alarm code latch and machine commands
	always_comb begin
		code_next  = code_reg;
		valid_next = valid_reg;
		if (!valid_reg) begin
			for (int i = NAL - 1; i >= 0; i--) begin
				if (latched[i]) begin
					code_next  = 4'(i + 1);
					valid_next = 1'b1; // [RQ22]
				end
			end
		end
		moff_next   = trip_f || (|fault) || (|pause) || (|latched); // [RQ20]
		inv_en_next = !(|(pause & INV_OFF_MASK)); // [RQ16]
		ares_next   = |areset; // [RQ20]
		stop_next   = |latched; // [RQ18]
		open_next   = |(latched & OPEN_MASK); // [RQ19]
		lock_next   = |(latched & LOCK_MASK); // [RQ10]
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			code_reg   <= 4'h0;
			valid_reg  <= 1'b0;
			moff_reg   <= 1'b0;
			inv_en_reg <= 1'b1;
			ares_reg   <= 1'b0;
			stop_reg   <= 1'b0;
			open_reg   <= 1'b0;
			lock_reg   <= 1'b0;
		end else begin
			code_reg   <= code_next;
			valid_reg  <= valid_next;
			moff_reg   <= moff_next;
			inv_en_reg <= inv_en_next;
			ares_reg   <= ares_next;
			stop_reg   <= stop_next;
			open_reg   <= open_next;
			lock_reg   <= lock_next;
		end
	end

	assign O_MOTOR_OFF        = moff_reg;
	assign O_INV_POWER_EN     = inv_en_reg;
	assign O_ALARM_RESET      = ares_reg;
	assign O_SAFE_STOP        = stop_reg;
	assign O_DOOR_OPEN        = open_reg;
	assign O_DOOR_KEEP_LOCKED = lock_reg;
	assign O_ALARM_VALID      = valid_reg;
	assign O_ALARM_CODE       = code_reg;
	assign O_HEAT_ALARM       = halarm_reg;
	assign O_LIMP_EN          = limp_reg;
	assign O_LIMP_CURRENT     = limp_reg ? LIMP_CURRENT_DA : 8'h00;
	assign O_LIMP_RPM         = limp_reg ? LIMP_RPM : 12'h000;

	// ==========================================================
	// Checks
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!rst_n);

	AST_SENSE_WINDOW: assert property ( // [RQ1]
		(I_SENSE_VALID && !half_pos && I_TRIAC_SENSE > NEG_HI) |=> out_reg)
		else $error("negative half sample above window not flagged");
	AST_TRIAC_ALARM: assert property ( // [RQ2]
		p_qual[P_TRIAC] |-> ##[1:3] O_ALARM_VALID)
		else $error("triac sensing fault not latched");
	AST_ELEC_TEST: assert property ( // [RQ5]
		I_ELEC_TEST |-> !p_cond[P_DIR])
		else $error("relay check active in electric test");
	AST_TRIP_OFF: assert property ( // [RQ6]
		trip_f |=> O_MOTOR_OFF)
		else $error("motor not off after current trip");
	AST_OC_OFF: assert property ( // [RQ7]
		(I_PHASE_CURRENT > cfg_reg[CFG_OC][7:0]) |=> O_MOTOR_OFF)
		else $error("motor not off on overcurrent");
	AST_NOTF_LOCK: assert property ( // [RQ10]
		latched[AL_NOTF] |=> O_DOOR_KEEP_LOCKED && !O_DOOR_OPEN)
		else $error("door not kept locked on not-following");
	AST_HEAT_EXPIRE: assert property ( // [RQ21]
		(hrun_reg && sec_reg && htmr_reg == 16'h0001 && !I_HEAT_START &&
		!I_HEAT_TARGET) |=> O_HEAT_ALARM)
		else $error("heating timeout expiry missed");
	AST_CODE_HOLD: assert property ( // [RQ22]
		O_ALARM_VALID |=> O_ALARM_VALID && $stable(O_ALARM_CODE))
		else $error("latched alarm code changed");
endmodule : mdfs_top

/* File: sim/mdfs_inv_model.sv */
`timescale 1ns/1ps
module mdfs_inv_model (
	input  wire logic i_clk,
	input  wire logic i_power_en,
	input  wire logic i_link_cut,
	input  wire logic i_spin,
	output logic      o_msg_ok,
	output logic      o_link_ok,
	output logic      o_tacho = 1'b0
);
	// ==========================================================
	// Messages only while powered, link cut on request
	assign o_msg_ok  = i_power_en;
	assign o_link_ok = ~i_link_cut;
	// Tacho level held four cycles so the pin filter passes it
	logic [1:0] ph_reg = 2'h0;
	always_ff @(posedge i_clk) begin
		ph_reg <= ph_reg + 2'h1;
		if (ph_reg == 2'h3) begin
			o_tacho <= i_spin & ~o_tacho;
		end
	end
endmodule : mdfs_inv_model

/* File: sim/mdfs_top_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	error_cnt++; $display("MISMATCH t=%0t got %h", $time, a); end end
module mdfs_top_tb import mdfs_pkg::*;;
	localparam int MS = 2;
	int error_cnt = 0, comparisons = 0;
	logic clk = 0, nrst = 0, sv = 0, hp = 1, nc = 0, cut = 0, hs = 0;
	logic ht = 0, key = 0, cwe = 0;
	logic trip = 0, snz = 0, mst = 0, spin = 0;
	logic [7:0] ts = 8'h80, pc = 8'h00;
	logic [9:0] tmp = 10'h019, bv = 10'h0E6;
	logic [2:0] csel = 3'h0;
	logic [15:0] cdat = 16'h0000, hto = 16'h0002;
	logic mok, lok, tach, moff, pwr, arst, sst, dop, dkl, av, hal, lim;
	logic [3:0] code;
	logic [7:0] lcur;
	logic [11:0] lrpm;
	// ==========================================================
	// Clock, partner, design
	initial forever #2.5 clk = ~clk;
	mdfs_inv_model inv (.i_clk(clk), .i_power_en(pwr), .i_link_cut(cut),
		.i_spin(spin), .o_msg_ok(mok), .o_link_ok(lok), .o_tacho(tach));
	mdfs_top #(.P_TICK_CYCLES(MS)) dut (.I_CORE_CLK(clk), .I_NRST(nrst),
		.I_TRIAC_SENSE(ts), .I_SENSE_VALID(sv), .I_HALF_POS(hp),
		.I_DOOR_CLOSED(1'b0), .I_TRIAC_DRIVEN(1'b0), .I_RELAYS_OPEN(1'b0),
		.I_ELEC_TEST(1'b0), .I_NORMAL_CYCLE(nc), .I_CUR_TRIP(trip),
		.I_PHASE_CURRENT(pc), .I_SPEED_NZ(snz), .I_MOTOR_START(mst),
		.I_TACHO(tach), .I_HS_TEMP(tmp), .I_BUS_VOLT(bv),
		.I_INV_MSG_OK(mok), .I_MC_LINK_OK(lok), .I_INV_CFG_REQ(1'b0),
		.I_CFG_WE(cwe), .I_CFG_SEL(csel), .I_CFG_DATA(cdat),
		.I_HEAT_START(hs), .I_HEAT_TARGET(ht), .I_HEAT_TIMEOUT_S(hto),
		.I_START_PAUSE(key), .O_MOTOR_OFF(moff), .O_INV_POWER_EN(pwr),
		.O_ALARM_RESET(arst), .O_SAFE_STOP(sst), .O_DOOR_OPEN(dop),
		.O_DOOR_KEEP_LOCKED(dkl), .O_ALARM_VALID(av), .O_ALARM_CODE(code),
		.O_HEAT_ALARM(hal), .O_LIMP_EN(lim), .O_LIMP_CURRENT(lcur),
		.O_LIMP_RPM(lrpm));
	// ==========================================================
	// Helpers
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	task automatic rst;
		nrst = 0;
		wt(16);
		nrst = 1;
		wt(8);
		`CHK(pwr, 1'b1)
		`CHK(av, 1'b0)
	endtask : rst
	task automatic pls(input logic [7:0] v);
		ts = v;
		sv = 1;
		wt(1);
		sv = 0;
	endtask : pls
	// ==========================================================
	// Scenarios
	task automatic s_triac;
		rst();
		pls(8'h66);
		wt(500 * MS);
		pls(8'h67);
		pls(8'hFB);
		wt(990 * MS);
		`CHK(av, 1'b0)
		wt(20 * MS);
		`CHK(code, 4'h1)
		`CHK(sst, 1'b1)
	endtask : s_triac
	task automatic s_bus;
		logic [9:0] v [2] = '{10'h0AE, 10'h1AF};
		for (int i = 0; i < 2; i++) begin
			rst();
			bv = v[i];
			wt(4 * MS);
			`CHK(av, 1'b0)
			wt(6 * MS);
			`CHK(code, 4'(7 + i))
			`CHK(moff, 1'b1)
			bv = 10'h0E6;
		end
	endtask : s_bus
	task automatic s_heat;
		rst();
		hs = 1;
		wt(1);
		hs = 0;
		wt(1500 * MS);
		`CHK(hal, 1'b0)
		wt(600 * MS);
		`CHK(hal, 1'b1)
	endtask : s_heat
	task automatic s_retry;
		logic [7:0] n;
		rst();
		nc = 1;
		cwe = 1;
		csel = CFG_OC;
		cdat = 16'h0014;
		wt(1);
		cwe = 0;
		pc = 8'h15;
		wt(5);
		pc = 8'h00;
		`CHK(moff, 1'b1)
		`CHK(pwr, 1'b0)
		wt(9990 * MS);
		`CHK(pwr, 1'b0)
		n = 8'h00;
		repeat (40 * MS) begin
			wt(1);
			n = n + 8'(arst);
		end
		`CHK(n, 8'h01)
		`CHK({pwr, moff, av}, 3'b100)
		nc = 0;
	endtask : s_retry
	task automatic s_comm;
		rst();
		cut = 1;
		wt(24990 * MS);
		`CHK(av, 1'b0)
		wt(20 * MS);
		key = 1;
		wt(1);
		key = 0;
		wt(4);
		`CHK(code, 4'hA)
		`CHK(av, 1'b1)
		cut = 0;
	endtask : s_comm
	task automatic s_trip;
		rst();
		trip = 1;
		wt(8);
		trip = 0;
		`CHK({code, moff, sst}, {4'h3, 2'b11})
		`CHK({dop, dkl}, 2'b10)
	endtask : s_trip
	task automatic s_tacho;
		rst();
		snz = 1;
		mst = 1;
		wt(1);
		mst = 0;
		wt(4);
		`CHK({lim, lcur, lrpm}, {1'b1, LIMP_CURRENT_DA, LIMP_RPM})
		spin = 1;
		wt(100 * MS);
		`CHK(lim, 1'b0)
		spin = 0;
		wt(2990 * MS);
		`CHK(av, 1'b0)
		wt(20 * MS);
		`CHK({code, dkl, dop, lim}, {4'h5, 3'b100})
		snz = 0;
	endtask : s_tacho
	task automatic end_of_test;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	initial begin
		s_triac();
		s_bus();
		s_heat();
		s_retry();
		s_comm();
		s_trip();
		s_tacho();
		end_of_test();
	end
endmodule : mdfs_top_tb
